// ### rtl/scg_map.svh
// Register map, field positions, reset values and timing counts.
// Assumes a 125 MHz pclk and a 32-bit APB register bus.
// Notes on behaviour
// R1: Carrier output mode is always on, on only with squelch, or off.
// R2: An enabled carrier output follows the signal being above threshold.
// R3: The carrier indicator shows whenever the enabled carrier output is on.
// R4: Stop-on-carrier halts sweep or scan while enabled and signal is present; the code halts only while the carrier output is also enabled.
// R5: Carrier output holds for a programmed hang time after signal drops.
// R6: The same hang keeps squelched audio unmuted until it expires.
// R7: Enter key or remote accept during hang dumps it and mutes audio.
// R8: After a dump a signal still present is detected afresh.
// R9: Latched hang lasts until the enter key or remote accept ends it.
// R10: With squelch on, audio mutes while signal is below threshold.
// R11: In full automatic gain the gain setting is the squelch threshold.
// R12: In threshold gain mode squelch sits 3 dB above the gain threshold.
// R13: Squelch cannot be selected while manual gain is active.
// R14: The squelch indicator shows while squelch is selected.
// R15: Gain mode button cycles full automatic, threshold, manual, repeating.
// R16: Gain setting is threshold in threshold mode, gain in manual mode.
// R17: Five decay settings, stepped longer or shorter by two buttons.
// R18: Locked-out decay settings are skipped and never selected; the code keeps a setting selected if it is locked while in use.
// R19: Hang counter restarts on signal drop, cancelled if signal returns.
`ifndef SCG_MAP_SVH
`define SCG_MAP_SVH
`define SCG_OFF_CTRL 8'h00
`define SCG_OFF_HANG 8'h04
`define SCG_OFF_LOCK 8'h08
`define SCG_OFF_GAIN 8'h0C
`define SCG_OFF_CMD 8'h10
`define SCG_OFF_STAT 8'h14
`define SCG_OFF_ISR 8'h18
`define SCG_OFF_IMR 8'h1C
`define SCG_CTRL_LATCH 2
`define SCG_CTRL_STOP 3
`define SCG_CMD_ACCEPT 0
`define SCG_EV_DETECT 0
`define SCG_EV_RELEASE 1
`define SCG_EV_DUMP 2
`define SCG_EV_STOP 3
`define SCG_NUM_EV 4
`define SCG_HANG_RST 16'h000A
`define SCG_NUM_DECAY 5
`define SCG_SQ_OFFSET_DB 9'h003
`define SCG_CLK_NS 8
`define SCG_TICK_NS 1000000
`endif

// ### rtl/scg_pkg.sv
// Types shared by the squelch, carrier output and gain control block.
// Assumes nothing of its surroundings.
package scg_pkg;
    typedef enum logic [1:0] {COR_ALWAYS, COR_SQONLY, COR_OFF} scg_cor_t;
    typedef enum logic [1:0] {GM_FULL, GM_THR, GM_MAN} scg_gain_t;
    typedef enum logic [1:0] {HS_IDLE, HS_OPEN, HS_HANG} scg_hang_t;
endpackage

// ### rtl/scg_squelch_cor.sv
// Squelch, carrier presence output with hang, gain mode and decay select.
// Assumes APB from logic on pclk; keys and level detector are async pins.
`timescale 1ns/100ps
`include "scg_map.svh"
module scg_squelch_cor #(
    parameter int TICK_CYC = `SCG_TICK_NS / `SCG_CLK_NS,
    parameter int NUM_DECAY = `SCG_NUM_DECAY
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic level_above,
    input wire logic squelch_key,
    input wire logic gain_mode_button,
    input wire logic decay_up_key,
    input wire logic decay_down_key,
    input wire logic enter_key,
    output logic carrier_presence_output,
    output logic carrier_ind,
    output logic squelch_indicator,
    output logic audio_mute,
    output logic scan_stop,
    output logic [1:0] gain_mode,
    output logic [7:0] gain_setting,
    output logic [7:0] squelch_level,
    output logic [$clog2(NUM_DECAY)-1:0] decay_sel,
    output logic irq
);
    localparam int DW = $clog2(NUM_DECAY);
    localparam int TW = $clog2(TICK_CYC);

    logic [5:0] pin_a, s1_r, s2_r, s3_r, rise;
    logic above, latch_r, stop_en_r, acc, do_wr, accept, sq_on_r;
    logic cor_en, tick;
    logic [1:0] cmode_r;
    logic [15:0] hang_len_r, hang_cnt_r;
    logic [NUM_DECAY-1:0] lock_r;
    logic [7:0] gain_r;
    logic [3:0] imr_r, isr_r, ev;
    logic [TW-1:0] tick_cnt_r;
    logic [8:0] sq_sum;
    logic [31:0] rd_nxt;
    scg_pkg::scg_gain_t gm_r, gm_nxt;
    scg_pkg::scg_hang_t hs_r, hs_nxt;
    // The registers sit on every aligned word from zero up to the mask.
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = a[1:0] == 2'h0 && a <= `SCG_OFF_IMR;
    endfunction

    // Nearest unlocked setting in the step direction; stays put if none.
    function automatic logic [DW-1:0] next_decay(
        input logic [DW-1:0] cur,
        input logic [NUM_DECAY-1:0] lock,
        input logic up
    );
        int c;
        logic found;
        next_decay = cur;
        found = 1'b0;
        for (int i = 1; i < NUM_DECAY; i++)
        begin
            c = up ? int'(cur) + i : int'(cur) - i;
            if (!found && c >= 0 && c < NUM_DECAY && !lock[c])
            begin
                next_decay = DW'(c);
                found = 1'b1;
            end
        end
    endfunction

    assign pin_a = {enter_key, decay_down_key, decay_up_key,
        gain_mode_button, squelch_key, level_above};
    // Two stages before use; the third stage only serves edge detection.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {s3_r, s2_r, s1_r} <= 18'h00000;
        else
            {s3_r, s2_r, s1_r} <= {s2_r, s1_r, pin_a};
    end
    assign rise = s2_r & ~s3_r;
    assign above = s2_r[0];

    assign acc = psel & penable & pready;
    assign do_wr = acc & pwrite;
    assign accept = rise[5] |
        (do_wr && paddr == `SCG_OFF_CMD && pwdata[`SCG_CMD_ACCEPT]); // R7

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmode_r <= 2'h0;
            latch_r <= 1'b0;
            stop_en_r <= 1'b0;
            hang_len_r <= `SCG_HANG_RST;
            lock_r <= '0;
            gain_r <= 8'h00;
            imr_r <= 4'h0;
        end
        else if (do_wr)
        begin
            unique case (paddr)
                `SCG_OFF_CTRL:
                begin
                    cmode_r <= pwdata[1:0];
                    latch_r <= pwdata[`SCG_CTRL_LATCH];
                    stop_en_r <= pwdata[`SCG_CTRL_STOP];
                end
                `SCG_OFF_HANG: hang_len_r <= pwdata[15:0];
                `SCG_OFF_LOCK: lock_r <= pwdata[NUM_DECAY-1:0];
                `SCG_OFF_GAIN: gain_r <= pwdata[7:0];
                `SCG_OFF_IMR: imr_r <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        unique case (paddr)
            `SCG_OFF_CTRL: rd_nxt = 32'({stop_en_r, latch_r, cmode_r});
            `SCG_OFF_HANG: rd_nxt = 32'(hang_len_r);
            `SCG_OFF_LOCK: rd_nxt = 32'(lock_r);
            `SCG_OFF_GAIN: rd_nxt = 32'(gain_r);
            `SCG_OFF_STAT: rd_nxt = 32'({decay_sel, 2'(gm_r),
                hs_r == scg_pkg::HS_HANG, sq_on_r, audio_mute,
                carrier_presence_output});
            `SCG_OFF_ISR: rd_nxt = 32'(isr_r);
            `SCG_OFF_IMR: rd_nxt = 32'(imr_r);
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    // One wait state: pready rises on the second access cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            prdata <= (psel & penable & ~pready & ~pwrite) ? rd_nxt :
                32'h0000_0000;
            pslverr <= psel & penable & ~pready & ~reg_hit(paddr);
        end
    end

    always_comb
    begin
        gm_nxt = gm_r;
        if (rise[2])
        begin
            unique case (gm_r)
                scg_pkg::GM_FULL: gm_nxt = scg_pkg::GM_THR; // R15
                scg_pkg::GM_THR: gm_nxt = scg_pkg::GM_MAN; // R15
                scg_pkg::GM_MAN: gm_nxt = scg_pkg::GM_FULL; // R15
                default: gm_nxt = scg_pkg::GM_FULL;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gm_r <= scg_pkg::GM_FULL;
        else
            gm_r <= gm_nxt;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sq_on_r <= 1'b0;
        else if (gm_nxt == scg_pkg::GM_MAN)
            sq_on_r <= 1'b0; // R13
        else if (rise[1])
            sq_on_r <= ~sq_on_r;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            decay_sel <= '0;
        else if (rise[3])
            decay_sel <= next_decay(decay_sel, lock_r, 1'b1); // R17 R18
        else if (rise[4])
            decay_sel <= next_decay(decay_sel, lock_r, 1'b0); // R17 R18
    end

    always_comb
    begin
        unique case (cmode_r)
            scg_pkg::COR_ALWAYS: cor_en = 1'b1; // R1
            scg_pkg::COR_SQONLY: cor_en = sq_on_r; // R1
            default: cor_en = 1'b0; // R1
        endcase
    end

    assign tick = tick_cnt_r == TW'(TICK_CYC - 1);
    always_comb
    begin
        hs_nxt = hs_r;
        ev[`SCG_EV_DETECT] = 1'b0;
        ev[`SCG_EV_RELEASE] = 1'b0;
        ev[`SCG_EV_DUMP] = 1'b0;
        ev[`SCG_EV_STOP] = stop_en_r & cor_en & ~scan_stop &
            (hs_r == scg_pkg::HS_OPEN);
        unique case (hs_r)
            scg_pkg::HS_IDLE:
                if (above)
                begin
                    hs_nxt = scg_pkg::HS_OPEN; // R2 R8
                    ev[`SCG_EV_DETECT] = 1'b1;
                end
            scg_pkg::HS_OPEN:
                if (!above && hang_len_r == 16'h0000 && !latch_r)
                begin
                    hs_nxt = scg_pkg::HS_IDLE;
                    ev[`SCG_EV_RELEASE] = 1'b1;
                end
                else if (!above)
                    hs_nxt = scg_pkg::HS_HANG; // R5 R19
            scg_pkg::HS_HANG:
                if (accept)
                begin
                    hs_nxt = scg_pkg::HS_IDLE; // R7 R9
                    ev[`SCG_EV_DUMP] = 1'b1;
                end
                else if (above)
                    hs_nxt = scg_pkg::HS_OPEN; // R19
                else if (!latch_r && hang_cnt_r == 16'h0000)
                begin
                    hs_nxt = scg_pkg::HS_IDLE; // R5
                    ev[`SCG_EV_RELEASE] = 1'b1;
                end
            default: hs_nxt = scg_pkg::HS_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hs_r <= scg_pkg::HS_IDLE;
        else
            hs_r <= hs_nxt;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hang_cnt_r <= 16'h0000;
            tick_cnt_r <= '0;
        end
        else if (hs_r != scg_pkg::HS_HANG)
        begin
            hang_cnt_r <= hang_len_r; // R19
            tick_cnt_r <= '0;
        end
        else
        begin
            tick_cnt_r <= tick ? '0 : tick_cnt_r + TW'(1);
            if (tick && hang_cnt_r != 16'h0000)
                hang_cnt_r <= hang_cnt_r - 16'h0001; // R5
        end
    end

    assign sq_sum = {1'b0, gain_r} + `SCG_SQ_OFFSET_DB;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            carrier_presence_output <= 1'b0;
            carrier_ind <= 1'b0;
            squelch_indicator <= 1'b0;
            audio_mute <= 1'b0;
            scan_stop <= 1'b0;
            gain_mode <= 2'h0;
            gain_setting <= 8'h00;
            squelch_level <= 8'h00;
        end
        else
        begin
            carrier_presence_output <= cor_en &
                (hs_r != scg_pkg::HS_IDLE); // R2 R5
            carrier_ind <= cor_en & (hs_r != scg_pkg::HS_IDLE); // R3
            squelch_indicator <= sq_on_r; // R14
            audio_mute <= sq_on_r & (hs_r == scg_pkg::HS_IDLE); // R6 R10
            scan_stop <= stop_en_r & cor_en &
                (hs_r == scg_pkg::HS_OPEN); // R4
            gain_mode <= 2'(gm_r);
            gain_setting <= gain_r; // R16
            if (gm_r == scg_pkg::GM_THR)
                squelch_level <= sq_sum[8] ? 8'hFF : sq_sum[7:0]; // R12
            else
                squelch_level <= gain_r; // R11
        end
    end

    // A hardware event in the cycle of its clear is kept.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            isr_r <= 4'h0;
            irq <= 1'b0;
        end
        else
        begin
            isr_r <= (isr_r & ~((do_wr && paddr == `SCG_OFF_ISR) ?
                pwdata[3:0] : 4'h0)) | ev;
            irq <= |(isr_r & imr_r);
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_r1;
        $past(cmode_r) == 2'h2 |-> !carrier_presence_output;
    endproperty
    a_r1: assert property (p_r1) else $error("carrier on while off"); // R1
    property p_r2;
        cor_en && hs_r == scg_pkg::HS_OPEN |=> carrier_presence_output;
    endproperty
    a_r2: assert property (p_r2) else $error("carrier not on"); // R2
    property p_r3;
        carrier_ind == carrier_presence_output;
    endproperty
    a_r3: assert property (p_r3) else $error("indicator mismatch"); // R3
    property p_r4;
        scan_stop |-> $past(stop_en_r && cor_en);
    endproperty
    a_r4: assert property (p_r4) else $error("stop without enable"); // R4
    property p_r5;
        hs_r == scg_pkg::HS_OPEN && !above && hang_len_r > 16'h0001
            |=> hs_r == scg_pkg::HS_HANG ##1
            (hs_r != scg_pkg::HS_IDLE || $past(accept));
    endproperty
    a_r5: assert property (p_r5) else $error("hang ended early"); // R5
    property p_r6;
        hs_r == scg_pkg::HS_HANG |=> !audio_mute;
    endproperty
    a_r6: assert property (p_r6) else $error("muted during hang"); // R6
    sequence s_dump;
        hs_r == scg_pkg::HS_HANG && accept;
    endsequence
    sequence s_dumped;
        hs_r == scg_pkg::HS_IDLE ##1 !carrier_presence_output;
    endsequence
    property p_r7;
        s_dump |=> s_dumped;
    endproperty
    a_r7: assert property (p_r7) else $error("dump not taken"); // R7
    property p_r8;
        hs_r == scg_pkg::HS_IDLE && above |=> hs_r == scg_pkg::HS_OPEN;
    endproperty
    a_r8: assert property (p_r8) else $error("signal not redetected"); // R8
    property p_r9;
        hs_r == scg_pkg::HS_HANG && latch_r && !accept && !above
            |=> hs_r == scg_pkg::HS_HANG;
    endproperty
    a_r9: assert property (p_r9) else $error("latched hang ended"); // R9
    property p_r10;
        sq_on_r && hs_r == scg_pkg::HS_IDLE |=> audio_mute;
    endproperty
    a_r10: assert property (p_r10) else $error("audio not muted"); // R10
    property p_r12;
        gm_r == scg_pkg::GM_THR && gain_r < 8'hFC
            |=> squelch_level == $past(gain_r) + 8'h03;
    endproperty
    a_r12: assert property (p_r12) else $error("squelch offset wrong"); // R12
    property p_r13;
        gm_r == scg_pkg::GM_MAN |-> !sq_on_r;
    endproperty
    a_r13: assert property (p_r13) else $error("squelch in manual"); // R13
    property p_r15;
        rise[2] && gm_r == scg_pkg::GM_MAN |=> gm_r == scg_pkg::GM_FULL;
    endproperty
    a_r15: assert property (p_r15) else $error("gain cycle wrong"); // R15
    property p_r18;
        $changed(decay_sel) && $stable(lock_r) |-> !lock_r[decay_sel];
    endproperty
    a_r18: assert property (p_r18) else $error("locked decay chosen"); // R18
endmodule // scg_squelch_cor

// ### testbench/scg_panel_model.sv
// Front panel keys and level detector driven from the bench.
// Assumes pclk from the bench; keys are pressed through tasks.
`timescale 1ns/100ps
module scg_panel_model (
    input wire logic pclk,
    output logic level_above,
    output logic [4:0] keys
);
    initial
    begin
        level_above = 1'b0;
        keys = 5'h00;
    end

    // A press is held four cycles and followed by four low cycles.
    task automatic press(input int k);
        @(posedge pclk);
        keys[k] <= 1'b1;
        repeat (4) @(posedge pclk);
        keys[k] <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask

    task automatic set_level(input logic v);
        @(posedge pclk);
        level_above <= v;
    endtask
endmodule // scg_panel_model

// ### testbench/squelch_cor_gain_control_tb.sv
// Self-checking bench for the squelch, carrier output and gain block.
// Assumes the block is reached over APB and the panel model drives pins.
`timescale 1ns/100ps
`include "scg_map.svh"
module squelch_cor_gain_control_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr, gain_setting, squelch_level;
    logic [31:0] pwdata, prdata, q;
    logic level_above, e;
    logic carrier_presence_output, carrier_ind, squelch_indicator;
    logic audio_mute, scan_stop;
    logic [1:0] gain_mode;
    logic [2:0] decay_sel;
    logic [4:0] keys;
    int failures = 0;
    int total_checks = 0;

    scg_squelch_cor #(.TICK_CYC(4)) u_scg_squelch_cor (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .level_above(level_above),
        .squelch_key(keys[0]), .gain_mode_button(keys[1]),
        .decay_up_key(keys[2]), .decay_down_key(keys[3]),
        .enter_key(keys[4]),
        .carrier_presence_output(carrier_presence_output),
        .carrier_ind(carrier_ind), .squelch_indicator(squelch_indicator),
        .audio_mute(audio_mute), .scan_stop(scan_stop),
        .gain_mode(gain_mode), .gain_setting(gain_setting),
        .squelch_level(squelch_level), .decay_sel(decay_sel), .irq(irq)
    );

    scg_panel_model u_scg_panel_model (
        .pclk(pclk), .level_above(level_above), .keys(keys)
    );

    always #4 pclk = ~pclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic clk(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic press(input int k);
        u_scg_panel_model.press(k);
    endtask

    task automatic level(input logic v, input int n);
        u_scg_panel_model.set_level(v);
        clk(n);
    endtask

    task automatic t_reset();
        check(gain_mode, 0);
        check(squelch_indicator, 0);
        check(decay_sel, 0);
        apb(1'b0, `SCG_OFF_HANG, 0);
        check(q, 32'h0000000A);
        apb(1'b0, 8'h20, 0);
        check(e, 1);
        check(q, 32'h00000000);
        apb(1'b0, 8'h02, 0);
        check(e, 1);
        $display("reset test done");
    endtask

    task automatic t_gain();
        apb(1'b1, `SCG_OFF_GAIN, 32'h00000040);
        press(0);
        check(squelch_indicator, 1);
        check(squelch_level, 8'h40);
        press(1);
        check(gain_mode, 1);
        check(squelch_level, 8'h43);
        check(gain_setting, 8'h40);
        apb(1'b1, `SCG_OFF_GAIN, 32'h000000FE);
        clk(3);
        check(squelch_level, 8'hFF);
        press(1);
        check(gain_mode, 2);
        check(squelch_indicator, 0);
        press(0);
        check(squelch_indicator, 0);
        check(gain_setting, 8'hFE);
        press(1);
        check(gain_mode, 0);
        press(0);
        check(squelch_indicator, 1);
        $display("gain test done");
    endtask

    task automatic t_modes();
        apb(1'b1, `SCG_OFF_HANG, 0);
        apb(1'b1, `SCG_OFF_CTRL, 32'h00000002);
        level(1'b1, 10);
        check({carrier_presence_output, carrier_ind}, 0);
        apb(1'b1, `SCG_OFF_CTRL, 32'h00000001);
        clk(4);
        check({carrier_presence_output, carrier_ind}, 3);
        press(0);
        check(carrier_presence_output, 0);
        press(0);
        apb(1'b1, `SCG_OFF_CTRL, 32'h00000008);
        clk(4);
        check({carrier_presence_output, scan_stop}, 3);
        apb(1'b1, `SCG_OFF_CTRL, 32'h0000000A);
        clk(4);
        check(scan_stop, 0);
        level(1'b0, 10);
        apb(1'b1, `SCG_OFF_CTRL, 0);
        $display("mode test done");
    endtask

    task automatic t_hang();
        apb(1'b1, `SCG_OFF_HANG, 32'h00000002);
        level(1'b1, 10);
        check({carrier_presence_output, audio_mute}, 2);
        level(1'b0, 6);
        check({carrier_presence_output, audio_mute}, 2);
        clk(20);
        check({carrier_presence_output, audio_mute}, 1);
        level(1'b1, 10);
        level(1'b0, 4);
        level(1'b1, 20);
        check(carrier_presence_output, 1);
        level(1'b0, 10);
        check(carrier_presence_output, 1);
        clk(20);
        check(carrier_presence_output, 0);
        $display("hang test done");
    endtask

    task automatic t_dump();
        apb(1'b0, `SCG_OFF_ISR, 0);
        check(q & 32'h3, 32'h3);
        check(irq, 0);
        apb(1'b1, `SCG_OFF_ISR, 32'h0000000F);
        apb(1'b1, `SCG_OFF_IMR, 32'h00000004);
        apb(1'b1, `SCG_OFF_CTRL, 32'h00000004);
        level(1'b1, 10);
        level(1'b0, 60);
        check(carrier_presence_output, 1);
        press(4);
        check({carrier_presence_output, audio_mute}, 1);
        check(irq, 1);
        apb(1'b0, `SCG_OFF_ISR, 0);
        check(q & 32'h4, 32'h4);
        apb(1'b1, `SCG_OFF_ISR, 32'h00000004);
        clk(3);
        check(irq, 0);
        apb(1'b1, `SCG_OFF_CTRL, 0);
        apb(1'b1, `SCG_OFF_HANG, 32'h00000010);
        level(1'b1, 10);
        level(1'b0, 10);
        check(carrier_presence_output, 1);
        apb(1'b1, `SCG_OFF_CMD, 32'h00000001);
        clk(3);
        check({carrier_presence_output, audio_mute}, 1);
        $display("dump test done");
    endtask

    task automatic t_decay();
        for (int i = 1; i <= 5; i++)
        begin
            press(2);
            check(decay_sel, (i > 4) ? 4 : i);
        end
        apb(1'b1, `SCG_OFF_LOCK, 32'h0000000A);
        press(3);
        check(decay_sel, 2);
        press(3);
        check(decay_sel, 0);
        press(2);
        check(decay_sel, 2);
        apb(1'b0, `SCG_OFF_STAT, 0);
        check(q, 32'h00000086);
        $display("decay test done");
    endtask

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        clk(20);
        presetn <= 1'b1;
        clk(4);
        t_reset();
        t_gain();
        t_modes();
        t_hang();
        t_dump();
        t_decay();
        complete_run();
    end

    // Cuts a hang short well after the tests should have ended.
    initial
    begin
        repeat (20000) @(posedge pclk);
        failures++;
        complete_run();
    end
endmodule // squelch_cor_gain_control_tb
